/* design/tbac_regs.svh */
// Constants of the 16-bit timer core: byte locations, fields, codes.
// Assumes inclusion by bare name from the timer design files.
`ifndef TBAC_REGS_SVH
`define TBAC_REGS_SVH

// Byte locations on the CPU port
`define TBAC_A_COUNT_LO 4'h0
`define TBAC_A_COUNT_HI 4'h1
`define TBAC_A_CMPA_LO 4'h2
`define TBAC_A_CMPA_HI 4'h3
`define TBAC_A_CMPB_LO 4'h4
`define TBAC_A_CMPB_HI 4'h5
`define TBAC_A_CAP_LO 4'h6
`define TBAC_A_CAP_HI 4'h7
`define TBAC_A_CTRL_A 4'h8
`define TBAC_A_CTRL_B 4'h9
`define TBAC_A_FLAGS 4'ha
`define TBAC_A_MASK 4'hb

// Reset values and the 16-bit maximum
`define TBAC_RST16 16'h0000
`define TBAC_RST8 8'h00
`define TBAC_RST4 4'h0
`define TBAC_MAX16 16'hffff

// Flag and mask bit positions
`define TBAC_F_OVF 0
`define TBAC_F_MA 1
`define TBAC_F_MB 2
`define TBAC_F_CAP 3

// Control B fields
`define TBAC_B_NOISE 7
`define TBAC_B_EDGE 6
`define TBAC_B_SRC 5

// Clock select codes
`define TBAC_CS_STOP 3'h0
`define TBAC_CS_DIV1 3'h1
`define TBAC_CS_DIV8 3'h2
`define TBAC_CS_DIV64 3'h3
`define TBAC_CS_DIV256 3'h4
`define TBAC_CS_DIV1024 3'h5
`define TBAC_CS_FALL 3'h6
`define TBAC_CS_RISE 3'h7

// Waveform mode codes {ctrl_b[4:3], ctrl_a[1:0]}
`define TBAC_WM_CTC_A 4'h4
`define TBAC_WM_CTC_CAP 4'hc
`define TBAC_WM_PWM_MAX 4'h7
`define TBAC_WM_PWM_CAP 4'he
`define TBAC_WM_PWM_A 4'hf

// Prescaler and capture filter sizes
`define TBAC_PRE_W 10
`define TBAC_NOISE_N 4

`endif

/* design/tbac_pkg.sv */
// Types shared by the 16-bit timer core.
// Assumes tbac_regs.svh for the numeric constants.
package tbac_pkg;
   typedef enum logic [2:0] {
      MODE_NORMAL, MODE_CTC_A, MODE_CTC_CAP, MODE_PWM_MAX, MODE_PWM_A, MODE_PWM_CAP
   } tbac_mode_t;

   // One CPU byte access
   typedef struct packed {
      logic wr;
      logic rd;
      logic [3:0] addr;
      logic [7:0] wdata;
   } tbac_cpu_req_t;
endpackage : tbac_pkg

/* design/tbac_prescale.sv */
// Free-running prescaler giving divide-by-8/64/256/1024 enables.
// Assumes one system clock; clear restarts all taps together.
`timescale 1ns/1ns
`include "tbac_regs.svh"
module tbac_prescale #(
   parameter int PRE_W = `TBAC_PRE_W
) (
   input wire logic sys_clk_i,
   input wire logic rst_n_i,
   input wire logic clear_i,
   output logic [3:0] tap_o
);
   localparam int TAP_W [4] = '{3, 6, 8, 10};
   logic [PRE_W-1:0] div_q;

   // Divider counter
   always_ff @(posedge sys_clk_i) begin
      if (!rst_n_i || clear_i) begin
         div_q <= '0;
      end else begin
         div_q <= div_q + 1'b1;
      end
   end

   // One-cycle enable as each tap wraps
   for (genvar g = 0; g < 4; g++) begin : g_tap
      assign tap_o[g] = &div_q[TAP_W[g]-1:0];
   end
endmodule : tbac_prescale

/* design/tbac_core.sv */
// 16-bit timer core with byte-wide CPU access through a shared latch.
// Assumes a CPU issuing at most one byte access per cycle, synchronous pins.
`timescale 1ns/1ns
`include "tbac_regs.svh"
module tbac_core (
   input wire logic sys_clk_i,
   input wire logic rst_n_i,
   input tbac_pkg::tbac_cpu_req_t cpu_req_i,
   input wire logic power_off_i,
   input wire logic prescale_clear_i,
   input wire logic external_count_pin_i,
   input wire logic capture_input_pin_i,
   input wire logic comparator_i,
   output logic [7:0] cpu_rdata_o,
   output logic [3:0] timer_flag_o,
   output logic irq_o,
   output logic wave_out_a_o,
   output logic wave_out_b_o
);
   import tbac_pkg::*;

   logic [15:0] timer_count_q;
   logic [7:0] hi_latch_q;
   logic [15:0] cmp_a_buf_q, cmp_a_act_q, cmp_b_buf_q, cmp_b_act_q;
   logic [15:0] capture_value_q;
   logic [7:0] timer_control_a_q, timer_control_b_q;
   logic [3:0] timer_flag_q, timer_mask_q;
   logic [7:0] rdata_q;
   logic irq_q, wave_a_q, wave_b_q;
   logic ext_smp_q, ext_prev_q;
   logic [`TBAC_NOISE_N-1:0] cap_hist_q;
   logic cap_filt_q, cap_prev_q;
   logic [3:0] pre_tap;
   logic [2:0] clock_select_field;
   tbac_mode_t mode;
   logic pwm, run, timer_tick, at_top, wrap;
   logic [15:0] top;
   logic ovf_ev, match_a_ev, match_b_ev, cap_ev, cap_raw, cap_next;
   logic [3:0] flag_set, flag_clr;

   // Decode waveform mode bits
   function automatic tbac_mode_t decode_mode(input logic [3:0] wm);
      case (wm)
         `TBAC_WM_CTC_A: decode_mode = MODE_CTC_A;
         `TBAC_WM_CTC_CAP: decode_mode = MODE_CTC_CAP;
         `TBAC_WM_PWM_MAX: decode_mode = MODE_PWM_MAX;
         `TBAC_WM_PWM_A: decode_mode = MODE_PWM_A;
         `TBAC_WM_PWM_CAP: decode_mode = MODE_PWM_CAP;
         default: decode_mode = MODE_NORMAL;
      endcase
   endfunction : decode_mode

   // Output compare pin: low for com 00, and pin A held low in MODE_PWM_A; in PWM set at wrap, clear at match for com 10, inverted for com 01/11;
   // toggle at match for com 01 otherwise
   function automatic logic wave_next(input logic cur, input logic [1:0] com, input logic pwm_m,
                                      input logic wrap_e, input logic match_e);
      wave_next = cur;
      if (com == 2'b00) begin
         wave_next = 1'b0;
      end else if (pwm_m) begin
         if (wrap_e) begin
            wave_next = ~com[0];
         end else if (match_e) begin
            wave_next = com[0];
         end
      end else if (match_e && com == 2'b01) begin
         wave_next = ~cur;
      end
   endfunction : wave_next

   function automatic logic is_write(input tbac_cpu_req_t r, input logic [3:0] a);
      is_write = r.wr && r.addr == a;
   endfunction : is_write

   function automatic logic is_read(input tbac_cpu_req_t r, input logic [3:0] a);
      is_read = r.rd && !r.wr && r.addr == a;
   endfunction : is_read

   tbac_prescale #(.PRE_W(`TBAC_PRE_W)) u_prescale (
      .sys_clk_i(sys_clk_i),
      .rst_n_i(rst_n_i),
      .clear_i(prescale_clear_i),
      .tap_o(pre_tap)
   );

   // Mode, top and run decode
   always_comb begin
      clock_select_field = timer_control_b_q[2:0];
      mode = decode_mode({timer_control_b_q[4:3], timer_control_a_q[1:0]});
      pwm = mode == MODE_PWM_MAX || mode == MODE_PWM_A || mode == MODE_PWM_CAP;
      run = !power_off_i;
      case (mode)
         MODE_CTC_A, MODE_PWM_A: top = cmp_a_act_q;
         MODE_CTC_CAP, MODE_PWM_CAP: top = capture_value_q;
         default: top = `TBAC_MAX16;
      endcase
      at_top = timer_count_q == top;
   end

   // Clock select: prescaler taps or pin edges
   always_comb begin
      case (clock_select_field)
         `TBAC_CS_STOP: timer_tick = 1'b0;
         `TBAC_CS_DIV1: timer_tick = 1'b1;
         `TBAC_CS_DIV8: timer_tick = pre_tap[0];
         `TBAC_CS_DIV64: timer_tick = pre_tap[1];
         `TBAC_CS_DIV256: timer_tick = pre_tap[2];
         `TBAC_CS_DIV1024: timer_tick = pre_tap[3];
         `TBAC_CS_FALL: timer_tick = ext_prev_q && !ext_smp_q;
         `TBAC_CS_RISE: timer_tick = !ext_prev_q && ext_smp_q;
         default: timer_tick = 1'b0;
      endcase
      timer_tick = timer_tick && run;
   end

   // Timer events
   always_comb begin
      wrap = timer_tick && at_top;
      ovf_ev = timer_tick && (pwm ? at_top : timer_count_q == `TBAC_MAX16);
      match_a_ev = timer_tick && timer_count_q == cmp_a_act_q;
      match_b_ev = timer_tick && timer_count_q == cmp_b_act_q;
   end

   // Pin sampling for the count source
   always_ff @(posedge sys_clk_i) begin
      if (!rst_n_i) begin
         ext_smp_q <= 1'b0;
         ext_prev_q <= 1'b0;
      end else begin
         ext_smp_q <= external_count_pin_i;
         ext_prev_q <= ext_smp_q;
      end
   end

   // Counter; CPU write wins over count and clear
   always_ff @(posedge sys_clk_i) begin
      if (!rst_n_i) begin
         timer_count_q <= `TBAC_RST16;
      end else if (is_write(cpu_req_i, `TBAC_A_COUNT_LO)) begin
         timer_count_q <= {hi_latch_q, cpu_req_i.wdata};
      end else if (timer_tick) begin
         timer_count_q <= at_top ? `TBAC_RST16 : timer_count_q + 16'h0001;
      end
   end

   // Shared high-byte latch
   always_ff @(posedge sys_clk_i) begin
      if (!rst_n_i) begin
         hi_latch_q <= `TBAC_RST8;
      end else if (cpu_req_i.wr && cpu_req_i.addr[0] && cpu_req_i.addr < `TBAC_A_CTRL_A) begin
         hi_latch_q <= cpu_req_i.wdata;
      end else if (is_read(cpu_req_i, `TBAC_A_COUNT_LO)) begin
         hi_latch_q <= timer_count_q[15:8];
      end else if (is_read(cpu_req_i, `TBAC_A_CAP_LO)) begin
         hi_latch_q <= capture_value_q[15:8];
      end
   end

   // Compare buffers and active values
   always_ff @(posedge sys_clk_i) begin
      if (!rst_n_i) begin
         cmp_a_buf_q <= `TBAC_RST16;
         cmp_b_buf_q <= `TBAC_RST16;
         cmp_a_act_q <= `TBAC_RST16;
         cmp_b_act_q <= `TBAC_RST16;
      end else begin
         if (is_write(cpu_req_i, `TBAC_A_CMPA_LO)) begin
            cmp_a_buf_q <= {hi_latch_q, cpu_req_i.wdata};
         end
         if (is_write(cpu_req_i, `TBAC_A_CMPB_LO)) begin
            cmp_b_buf_q <= {hi_latch_q, cpu_req_i.wdata};
         end
         if (!pwm || wrap) begin
            cmp_a_act_q <= cmp_a_buf_q;
            cmp_b_act_q <= cmp_b_buf_q;
         end
      end
   end

   // Capture source, noise filter and edge detect
   always_comb begin
      cap_raw = timer_control_b_q[`TBAC_B_SRC] ? comparator_i : capture_input_pin_i;
      cap_next = cap_filt_q;
      if (!timer_control_b_q[`TBAC_B_NOISE]) begin
         cap_next = cap_hist_q[0];
      end else if (&cap_hist_q) begin
         cap_next = 1'b1;
      end else if (~|cap_hist_q) begin
         cap_next = 1'b0;
      end
      cap_ev = run && mode != MODE_CTC_CAP && mode != MODE_PWM_CAP &&
         (timer_control_b_q[`TBAC_B_EDGE] ? (cap_filt_q && !cap_prev_q) : (!cap_filt_q && cap_prev_q));
   end

   always_ff @(posedge sys_clk_i) begin
      if (!rst_n_i) begin
         cap_hist_q <= `TBAC_RST4;
         cap_filt_q <= 1'b0;
         cap_prev_q <= 1'b0;
      end else begin
         cap_hist_q <= {cap_hist_q[`TBAC_NOISE_N-2:0], cap_raw};
         cap_filt_q <= cap_next;
         cap_prev_q <= cap_filt_q;
      end
   end

   // Capture register: CPU write wins over an edge
   always_ff @(posedge sys_clk_i) begin
      if (!rst_n_i) begin
         capture_value_q <= `TBAC_RST16;
      end else if (is_write(cpu_req_i, `TBAC_A_CAP_LO)) begin
         capture_value_q <= {hi_latch_q, cpu_req_i.wdata};
      end else if (cap_ev) begin
         capture_value_q <= timer_count_q;
      end
   end

   // Control and mask registers
   always_ff @(posedge sys_clk_i) begin
      if (!rst_n_i) begin
         timer_control_a_q <= `TBAC_RST8;
         timer_control_b_q <= `TBAC_RST8;
         timer_mask_q <= `TBAC_RST4;
      end else begin
         if (is_write(cpu_req_i, `TBAC_A_CTRL_A)) begin
            timer_control_a_q <= cpu_req_i.wdata;
         end
         if (is_write(cpu_req_i, `TBAC_A_CTRL_B)) begin
            timer_control_b_q <= cpu_req_i.wdata;
         end
         if (is_write(cpu_req_i, `TBAC_A_MASK)) begin
            timer_mask_q <= cpu_req_i.wdata[3:0];
         end
      end
   end

   // Flags: write one to clear, a new event wins
   always_comb begin
      flag_set = '0;
      flag_set[`TBAC_F_OVF] = ovf_ev;
      flag_set[`TBAC_F_MA] = match_a_ev;
      flag_set[`TBAC_F_MB] = match_b_ev;
      flag_set[`TBAC_F_CAP] = cap_ev;
      flag_clr = is_write(cpu_req_i, `TBAC_A_FLAGS) ? cpu_req_i.wdata[3:0] : 4'h0;
   end

   always_ff @(posedge sys_clk_i) begin
      if (!rst_n_i) begin
         timer_flag_q <= `TBAC_RST4;
         irq_q <= 1'b0;
      end else begin
         timer_flag_q <= (timer_flag_q & ~flag_clr) | flag_set;
         irq_q <= |(timer_flag_q & timer_mask_q);
      end
   end

   // Waveform pins
   always_ff @(posedge sys_clk_i) begin
      if (!rst_n_i) begin
         wave_a_q <= 1'b0;
         wave_b_q <= 1'b0;
      end else begin
         wave_a_q <= (mode == MODE_PWM_A) ? 1'b0 :
            wave_next(wave_a_q, timer_control_a_q[7:6], pwm, wrap, match_a_ev);
         wave_b_q <= wave_next(wave_b_q, timer_control_a_q[5:4], pwm, wrap, match_b_ev);
      end
   end

   // Read data, one cycle after the strobe
   always_ff @(posedge sys_clk_i) begin
      if (!rst_n_i) begin
         rdata_q <= `TBAC_RST8;
      end else if (cpu_req_i.rd && !cpu_req_i.wr) begin
         case (cpu_req_i.addr)
            `TBAC_A_COUNT_LO: rdata_q <= timer_count_q[7:0];
            `TBAC_A_CMPA_LO: rdata_q <= cmp_a_buf_q[7:0];
            `TBAC_A_CMPA_HI: rdata_q <= cmp_a_buf_q[15:8];
            `TBAC_A_CMPB_LO: rdata_q <= cmp_b_buf_q[7:0];
            `TBAC_A_CMPB_HI: rdata_q <= cmp_b_buf_q[15:8];
            `TBAC_A_CAP_LO: rdata_q <= capture_value_q[7:0];
            `TBAC_A_COUNT_HI, `TBAC_A_CAP_HI: rdata_q <= hi_latch_q;
            `TBAC_A_CTRL_A: rdata_q <= timer_control_a_q;
            `TBAC_A_CTRL_B: rdata_q <= timer_control_b_q;
            `TBAC_A_FLAGS: rdata_q <= {4'h0, timer_flag_q};
            `TBAC_A_MASK: rdata_q <= {4'h0, timer_mask_q};
            default: rdata_q <= `TBAC_RST8;
         endcase
      end
   end

   assign cpu_rdata_o = rdata_q;
   assign timer_flag_o = timer_flag_q;
   assign irq_o = irq_q;
   assign wave_out_a_o = wave_a_q;
   assign wave_out_b_o = wave_b_q;

   // Checks
   default clocking cb @(posedge sys_clk_i); endclocking
   default disable iff (!rst_n_i);

   property p_low_write;
      is_write(cpu_req_i, `TBAC_A_COUNT_LO) |=> timer_count_q == {$past(hi_latch_q), $past(cpu_req_i.wdata)};
   endproperty
   a_low_write: assert property (p_low_write) else $error("counter low write wrong");

   property p_low_read;
      is_read(cpu_req_i, `TBAC_A_COUNT_LO) |=>
         hi_latch_q == $past(timer_count_q[15:8]) && cpu_rdata_o == $past(timer_count_q[7:0]);
   endproperty
   a_low_read: assert property (p_low_read) else $error("counter low read wrong");

   property p_cmp_read;
      (is_read(cpu_req_i, `TBAC_A_CMPA_HI) || is_read(cpu_req_i, `TBAC_A_CMPB_LO)) |=> $stable(hi_latch_q);
   endproperty
   a_cmp_read: assert property (p_cmp_read) else $error("compare read moved latch");

   property p_hi_read;
      is_read(cpu_req_i, `TBAC_A_COUNT_HI) |=> cpu_rdata_o == $past(hi_latch_q);
   endproperty
   a_hi_read: assert property (p_hi_read) else $error("high read not latch");

   property p_hi_write;
      is_write(cpu_req_i, `TBAC_A_COUNT_HI) && !timer_tick |=>
         $stable(timer_count_q) && hi_latch_q == $past(cpu_req_i.wdata);
   endproperty
   a_hi_write: assert property (p_hi_write) else $error("high write moved counter");

   property p_stop;
      clock_select_field == `TBAC_CS_STOP && !cpu_req_i.wr [*2] |-> $stable(timer_count_q);
   endproperty
   a_stop: assert property (p_stop) else $error("counter moved while stopped");

   property p_div1;
      clock_select_field == `TBAC_CS_DIV1 && run && mode == MODE_NORMAL && !cpu_req_i.wr &&
         timer_count_q != `TBAC_MAX16 |=> timer_count_q == $past(timer_count_q) + 16'h0001;
   endproperty
   a_div1: assert property (p_div1) else $error("direct clock did not count");

   property p_rise;
      $rose(external_count_pin_i) && clock_select_field == `TBAC_CS_RISE && run |=>
         timer_tick || clock_select_field != `TBAC_CS_RISE || !run;
   endproperty
   a_rise: assert property (p_rise) else $error("rising pin edge missed");

   property p_prio;
      is_write(cpu_req_i, `TBAC_A_COUNT_LO) && timer_tick |=> timer_count_q[7:0] == $past(cpu_req_i.wdata);
   endproperty
   a_prio: assert property (p_prio) else $error("count beat cpu write");

   property p_match;
      match_a_ev ##1 !is_write(cpu_req_i, `TBAC_A_FLAGS) |=> timer_flag_q[`TBAC_F_MA];
   endproperty
   a_match: assert property (p_match) else $error("match flag lost");

   property p_dbuf;
      pwm && !wrap && is_write(cpu_req_i, `TBAC_A_CMPA_LO) |=> $stable(cmp_a_act_q);
   endproperty
   a_dbuf: assert property (p_dbuf) else $error("compare updated early");

   property p_irq;
      |(timer_flag_q & timer_mask_q) |=> irq_o;
   endproperty
   a_irq: assert property (p_irq) else $error("masked flag gave no request");

   property p_reset;
      $rose(rst_n_i) |-> timer_count_q == 16'h0000 && hi_latch_q == 8'h00 && timer_flag_q == 4'h0;
   endproperty
   a_reset: assert property (p_reset) else $error("state not cleared");

   property p_cov_ovf;
      ovf_ev;
   endproperty
   c_ovf: cover property (p_cov_ovf);

   property p_cov_cap;
      cap_ev ##1 is_read(cpu_req_i, `TBAC_A_CAP_LO);
   endproperty
   c_cap: cover property (p_cov_cap);

   property p_cov_pair;
      is_write(cpu_req_i, `TBAC_A_COUNT_HI) ##1 is_write(cpu_req_i, `TBAC_A_COUNT_LO);
   endproperty
   c_pair: cover property (p_cov_pair);
endmodule : tbac_core

/* test/tbac_cpu_model.sv */
// Byte-wide CPU model that reaches the timer core through its access port.
// Assumes the core takes a request at the rising edge and answers one cycle later.
`timescale 1ns/1ns
module tbac_cpu_model (
   input wire logic sys_clk_i,
   input wire logic [7:0] cpu_rdata_i,
   output tbac_pkg::tbac_cpu_req_t cpu_req_o,
   output logic power_off_o
);
   import tbac_pkg::*;

   // Power-off bit kept clear so the timer runs
   initial power_off_o = 1'b0;
   initial cpu_req_o = '0;

   // One access: drive at the falling edge, hold through the taking edge, then release
   task automatic access(input logic wr, input logic [3:0] a, input logic [7:0] v, output logic [7:0] d);
      @(negedge sys_clk_i);
      cpu_req_o = '{wr: wr, rd: ~wr, addr: a, wdata: v};
      @(posedge sys_clk_i);
      @(negedge sys_clk_i);
      d = cpu_rdata_i;
      // Released bus carries cleared qualifiers and inverted address and data, never the stale value
      cpu_req_o = '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~v};
   endtask : access

   task automatic wr8(input logic [3:0] a, input logic [7:0] v);
      logic [7:0] unused;
      access(1'b1, a, v, unused);
   endtask : wr8

   task automatic rd8(input logic [3:0] a, output logic [7:0] d);
      access(1'b0, a, 8'h00, d);
   endtask : rd8

   // High byte first so the low-byte write commits the pair
   task automatic wr16(input logic [3:0] lo, input logic [15:0] v);
      wr8(lo + 4'h1, v[15:8]);
      wr8(lo, v[7:0]);
   endtask : wr16

   // Low byte first fills the latch; nothing slips in between the two reads
   task automatic rd16(input logic [3:0] lo, output logic [15:0] d);
      rd8(lo, d[7:0]);
      rd8(lo + 4'h1, d[15:8]);
   endtask : rd16
endmodule : tbac_cpu_model

/* test/tbac_core_test.sv */
// Self-checking bench for the 16-bit timer core with byte-wide access.
// Assumes the CPU model drives the access port; pins driven at the falling edge.
`timescale 1ns/1ns
`include "tbac_regs.svh"
`define CHECK(what, exp, got) \
   begin \
      total_checks++; \
      if ((got) !== (exp)) begin \
         n_mismatch++; \
         $display("ERROR %s expected %0h seen %0h", what, exp, got); \
      end \
   end
module tbac_core_test;
   import tbac_pkg::*;
   logic sys_clk_i = 1'b0;
   logic rst_n_i = 1'b0;
   logic ext_pin = 1'b0;
   logic cap_pin = 1'b0;
   tbac_cpu_req_t req;
   logic power_off;
   logic [7:0] rdata;
   logic [3:0] flags;
   logic irq, wave_a, wave_b;
   int n_mismatch = 0;
   int total_checks = 0;
   logic [7:0] d;
   logic [15:0] c;

   tbac_core DUT (.sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .cpu_req_i(req), .power_off_i(power_off),
      .prescale_clear_i(1'b0), .external_count_pin_i(ext_pin), .capture_input_pin_i(cap_pin),
      .comparator_i(1'b0), .cpu_rdata_o(rdata), .timer_flag_o(flags), .irq_o(irq),
      .wave_out_a_o(wave_a), .wave_out_b_o(wave_b));
   tbac_cpu_model cpu (.sys_clk_i(sys_clk_i), .cpu_rdata_i(rdata), .cpu_req_o(req), .power_off_o(power_off));

   // 50 MHz system clock
   always #10 sys_clk_i = ~sys_clk_i;

   task automatic idle(input int n);
      repeat (n) @(negedge sys_clk_i);
   endtask : idle

   task automatic give_verdict();
      $display("checks %0d mismatches %0d", total_checks, n_mismatch);
      if (n_mismatch == 0 && total_checks > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask : give_verdict

   // Every location, unmapped ones too, reads zero after reset
   task automatic t_reset();
      for (int a = 0; a < 16; a++) begin
         cpu.rd8(4'(a), d);
         `CHECK("reset read", 8'h00, d);
      end
      `CHECK("reset outputs", 7'h00, {flags, irq, wave_a, wave_b});
   endtask : t_reset

   // Byte sequencing through the shared latch
   task automatic t_bytes();
      cpu.wr16(`TBAC_A_COUNT_LO, 16'h01ff);
      cpu.rd16(`TBAC_A_COUNT_LO, c);
      `CHECK("count pair", 16'h01ff, c);
      cpu.wr8(`TBAC_A_COUNT_HI, 8'h55);
      idle(20);
      cpu.rd16(`TBAC_A_COUNT_LO, c);
      `CHECK("count after high only", 16'h01ff, c);
      cpu.wr8(`TBAC_A_CMPA_HI, 8'h12);
      cpu.wr8(`TBAC_A_CMPA_LO, 8'h34);
      cpu.wr8(`TBAC_A_CMPB_LO, 8'h56);
      cpu.rd8(`TBAC_A_COUNT_LO, d);
      cpu.rd8(`TBAC_A_CMPA_HI, d);
      `CHECK("compare a high", 8'h12, d);
      cpu.rd8(`TBAC_A_CMPB_HI, d);
      `CHECK("compare b shared high", 8'h12, d);
      cpu.rd8(`TBAC_A_CMPB_LO, d);
      `CHECK("compare b low", 8'h56, d);
      cpu.rd8(`TBAC_A_COUNT_HI, d);
      `CHECK("latch untouched", 8'h01, d);
      cpu.wr16(`TBAC_A_CAP_LO, 16'hbeef);
      cpu.rd16(`TBAC_A_CAP_LO, c);
      `CHECK("capture pair", 16'hbeef, c);
   endtask : t_bytes

   // Control registers read back directly
   task automatic t_ctrl();
      cpu.wr8(`TBAC_A_CTRL_A, 8'ha4);
      cpu.wr8(`TBAC_A_CTRL_B, 8'he0);
      cpu.rd8(`TBAC_A_CTRL_A, d);
      `CHECK("control a", 8'ha4, d);
      cpu.rd8(`TBAC_A_CTRL_B, d);
      `CHECK("control b", 8'he0, d);
      cpu.wr8(`TBAC_A_CTRL_A, 8'h00);
      cpu.wr8(`TBAC_A_CTRL_B, 8'h00);
   endtask : t_ctrl

   // Each divider code gives exactly four ticks over four of its periods
   task automatic t_prescale();
      int div[5] = '{1, 8, 64, 256, 1024};
      for (int k = 0; k < 5; k++) begin
         cpu.wr16(`TBAC_A_COUNT_LO, 16'h0000);
         cpu.wr8(`TBAC_A_CTRL_B, 8'(k + 1));
         idle(4 * div[k] - 2);
         cpu.wr8(`TBAC_A_CTRL_B, 8'h00);
         cpu.rd16(`TBAC_A_COUNT_LO, c);
         `CHECK("divided count", 16'h0004, c);
      end
   endtask : t_prescale

   // Rising and falling pin edges, three of each
   task automatic t_pin();
      logic [2:0] code[2] = '{`TBAC_CS_RISE, `TBAC_CS_FALL};
      for (int k = 0; k < 2; k++) begin
         cpu.wr16(`TBAC_A_COUNT_LO, 16'h0000);
         cpu.wr8(`TBAC_A_CTRL_B, {5'h00, code[k]});
         repeat (3) begin
            idle(3);
            ext_pin = ~ext_pin;
            idle(3);
            ext_pin = ~ext_pin;
         end
         idle(4);
         cpu.wr8(`TBAC_A_CTRL_B, 8'h00);
         cpu.rd16(`TBAC_A_COUNT_LO, c);
         `CHECK("pin edge count", 16'h0003, c);
      end
   endtask : t_pin

   // Write while counting every cycle must land exactly
   task automatic t_priority();
      cpu.wr8(`TBAC_A_CTRL_B, 8'h01);
      cpu.wr16(`TBAC_A_COUNT_LO, 16'h1234);
      cpu.wr8(`TBAC_A_CTRL_B, 8'h00);
      cpu.rd16(`TBAC_A_COUNT_LO, c);
      `CHECK("write beats count", 16'h1236, c);
   endtask : t_priority

   // Match, mask, clear, overflow and capture flags
   task automatic t_events();
      cpu.wr8(`TBAC_A_FLAGS, 8'h0f);
      cpu.wr16(`TBAC_A_CMPA_LO, 16'h0020);
      cpu.wr16(`TBAC_A_CMPB_LO, 16'h0030);
      cpu.wr8(`TBAC_A_CTRL_A, 8'h50);
      cpu.wr16(`TBAC_A_COUNT_LO, 16'h0000);
      cpu.wr8(`TBAC_A_CTRL_B, 8'h01);
      idle(64);
      cpu.wr8(`TBAC_A_CTRL_B, 8'h00);
      `CHECK("match flags", 4'b0110, flags);
      `CHECK("masked irq", 1'b0, irq);
      `CHECK("toggle on match", 1'b1, wave_a);
      `CHECK("toggle on match b", 1'b1, wave_b);
      cpu.wr8(`TBAC_A_MASK, 8'h02);
      idle(2);
      `CHECK("unmasked irq", 1'b1, irq);
      cpu.wr8(`TBAC_A_FLAGS, 8'h06);
      idle(2);
      `CHECK("cleared flags", 5'h00, {flags, irq});
      cpu.wr16(`TBAC_A_COUNT_LO, 16'hfff0);
      cpu.wr8(`TBAC_A_CTRL_B, 8'h01);
      idle(32);
      cpu.wr8(`TBAC_A_CTRL_B, 8'h00);
      `CHECK("overflow flag", 4'b0001, flags);
      cpu.wr8(`TBAC_A_FLAGS, 8'h0f);
      cpu.wr16(`TBAC_A_COUNT_LO, 16'h0100);
      cpu.wr8(`TBAC_A_CTRL_B, 8'h41);
      idle(4);
      cap_pin = 1'b1;
      idle(8);
      cpu.wr8(`TBAC_A_CTRL_B, 8'h40);
      cpu.rd16(`TBAC_A_CAP_LO, c);
      `CHECK("captured count", 1'b1, (c >= 16'h0100 && c <= 16'h0118));
      `CHECK("capture flag", 4'b1000, flags);
   endtask : t_events

   // Top taken from compare a: counter never passes it
   task automatic t_ctc();
      cpu.wr8(`TBAC_A_CTRL_A, 8'h00);
      cpu.wr16(`TBAC_A_CMPA_LO, 16'h0005);
      cpu.wr16(`TBAC_A_COUNT_LO, 16'h0000);
      cpu.wr8(`TBAC_A_CTRL_B, 8'h09);
      idle(50);
      cpu.wr8(`TBAC_A_CTRL_B, 8'h08);
      cpu.rd16(`TBAC_A_COUNT_LO, c);
      `CHECK("count within top", 1'b1, (c <= 16'h0005));
      // PWM: a new compare value waits for the wrap, old one still matches
      cpu.wr8(`TBAC_A_CTRL_A, 8'h03);
      cpu.wr16(`TBAC_A_CMPA_LO, 16'h0007);
      cpu.wr16(`TBAC_A_COUNT_LO, 16'h0000);
      cpu.wr8(`TBAC_A_FLAGS, 8'h0f);
      cpu.wr8(`TBAC_A_CTRL_B, 8'h09);
      idle(4);
      cpu.wr8(`TBAC_A_CTRL_B, 8'h08);
      `CHECK("buffered compare held", 4'b0010, flags);
      cpu.rd16(`TBAC_A_CMPA_LO, c);
      `CHECK("compare buffer read", 16'h0007, c);
   endtask : t_ctc

   // Watchdog well past the expected run length
   initial begin
      repeat (60000) @(posedge sys_clk_i);
      n_mismatch++;
      give_verdict();
   end

   // Reset for 12 cycles, then the scenarios in turn
   initial begin
      repeat (12) @(posedge sys_clk_i);
      @(negedge sys_clk_i);
      rst_n_i = 1'b1;
      t_reset();
      t_bytes();
      t_ctrl();
      t_prescale();
      t_pin();
      t_priority();
      t_events();
      t_ctc();
      give_verdict();
   end
endmodule : tbac_core_test
